// [core/wrba_pkg.sv]
/*
 * shared constants for the waveform ram block access link:
 * register indices, field positions, command codes, timing.
 * assumes nothing beyond a systemverilog compiler.
 */
`default_nettype none
package wrba_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 5;
    localparam int RAM_AW = 10;
    localparam int RAM_DEPTH = 1024;
    localparam int SAMPLE_W = 12;
    localparam int MODE_W = 2;

    // ----------------------------------------------------------------
    // register indices on the control link
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_REFERENCE = 5'h00;
    localparam logic [4:0] REG_CONFIG = 5'h05;
    localparam logic [4:0] REG_COMM = 5'h0b;
    localparam logic [4:0] REG_RAM_DATA = 5'h1b;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int CFG_MODE_LSB = 9;
    localparam int COMM_SEL_LSB = 0;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [4:0] SEL_RESET = 5'h1e;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ----------------------------------------------------------------
    // command codes and play modes
    // ----------------------------------------------------------------
    localparam logic [15:0] CMD_BURST_STORE = 16'h0014;
    localparam logic [15:0] CMD_DUMP = 16'h0015;
    localparam logic [15:0] CMD_DUMP_ABORT = 16'hff15;
    localparam logic [15:0] FILLER_WORD = 16'h0000;
    localparam logic [1:0] MODE_RAM_PLAY = 2'h2;
    localparam logic [1:0] MODE_RAM_SYNTH = 2'h3;
    localparam logic [9:0] RAM_LAST = 10'h3ff;
    localparam logic [9:0] COUNT_ZERO = 10'h000;
    localparam logic [9:0] COUNT_ONE = 10'h001;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    // device interpreter states
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_COUNT = 3'h2,
        ST_DATA = 3'h3,
        ST_DUMP = 3'h4
    } wrba_state_t;

    // host transfer states
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0,
        HS_WAIT = 2'h1,
        HS_DRIVE = 2'h2,
        HS_HOLD = 2'h3
    } wrba_hstate_t;
endpackage : wrba_pkg
`default_nettype wire

// [core/wrba_link_if.sv]
/*
 * control link between host controller and waveform ram device.
 * assumes both ends run on their own core clock; link_clk is made
 * by the host and sampled by the device.
 */
`timescale 1ns/1ps
`default_nettype none
interface wrba_link_if;
    logic link_clk;
    logic wr_en;
    logic rd_en;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport host_mp (
        output link_clk,
        output wr_en,
        output rd_en,
        output addr,
        output wdata,
        input rdata
    );

    modport dev_mp (
        input link_clk,
        input wr_en,
        input rd_en,
        input addr,
        input wdata,
        output rdata
    );
endinterface : wrba_link_if
`default_nettype wire

// [core/wrba_device.sv]
/*
 * device end: command interpreter for burst store into the waveform
 * ram and full-ram dump through the readback register.
 * assumes the host changes link strobes on the falling link_clk edge
 * and holds them a full link period; all link inputs are async here.
 */
`timescale 1ns/1ps
`default_nettype none

module wrba_device (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // control link
    wrba_link_if.dev_mp link,
    // playback side
    input wire logic [9:0] pb_addr,
    output logic [15:0] pb_data,
    output logic [11:0] ref_sample,
    output logic [1:0] play_mode,
    output logic dump_active
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic lclk_s1;
        logic lclk_s2;
        logic lclk_prev;
        logic wr_s1;
        logic wr_s2;
        logic rd_s1;
        logic rd_s2;
        logic [4:0] addr_s1;
        logic [4:0] addr_s2;
        logic [15:0] data_s1;
        logic [15:0] data_s2;
        wrba_pkg::wrba_state_t state;
        logic [9:0] waddr;
        logic [9:0] wcnt;
        logic [9:0] raddr;
        logic last;
        logic [1:0] mode;
        logic [4:0] readback_select;
        logic [15:0] sample;
        logic [15:0] ram_data;
        logic [15:0] rdata;
        logic [15:0] pb_data;
    } wrba_dev_t;

    wrba_dev_t s_q;
    wrba_dev_t s_d;
    logic [15:0] ram [wrba_pkg::RAM_DEPTH];
    logic ram_we;
    logic [9:0] ram_wa;
    logic [15:0] ram_wd;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // link inputs pass two flops; edge found on the second stage only
    always_comb begin
        logic edge_up;
        logic wr_ref;
        edge_up = 1'b0;
        wr_ref = 1'b0;
        s_d = s_q;
        ram_we = 1'b0;
        ram_wa = s_q.waddr;
        ram_wd = s_q.data_s2;
        s_d.lclk_s1 = link.link_clk;
        s_d.lclk_s2 = s_q.lclk_s1;
        s_d.lclk_prev = s_q.lclk_s2;
        s_d.wr_s1 = link.wr_en;
        s_d.wr_s2 = s_q.wr_s1;
        s_d.rd_s1 = link.rd_en;
        s_d.rd_s2 = s_q.rd_s1;
        s_d.addr_s1 = link.addr;
        s_d.addr_s2 = s_q.addr_s1;
        s_d.data_s1 = link.wdata;
        s_d.data_s2 = s_q.data_s1;
        s_d.pb_data = ram[pb_addr];
        edge_up = s_q.lclk_s2 && !s_q.lclk_prev;
        wr_ref = edge_up && s_q.wr_s2 && (s_q.addr_s2 == wrba_pkg::REG_REFERENCE);

        // configuration writes land at any time, even mid-dump
        if (edge_up && s_q.wr_s2) begin
            if (s_q.addr_s2 == wrba_pkg::REG_CONFIG) begin
                s_d.mode = s_q.data_s2[wrba_pkg::CFG_MODE_LSB +: wrba_pkg::MODE_W];
            end
            if (s_q.addr_s2 == wrba_pkg::REG_COMM) begin
                s_d.readback_select = s_q.data_s2[wrba_pkg::COMM_SEL_LSB +: wrba_pkg::ADDR_W];
            end
        end

        // readback word is whatever the select field routes out
        if (edge_up && s_q.rd_s2) begin
            case (s_q.readback_select)
                wrba_pkg::REG_RAM_DATA: s_d.rdata = s_q.ram_data;
                wrba_pkg::REG_REFERENCE: s_d.rdata = s_q.sample;
                wrba_pkg::REG_CONFIG: begin
                    s_d.rdata = wrba_pkg::WORD_ZERO;
                    s_d.rdata[wrba_pkg::CFG_MODE_LSB +: wrba_pkg::MODE_W] = s_q.mode;
                end
                wrba_pkg::REG_COMM: begin
                    s_d.rdata = wrba_pkg::WORD_ZERO;
                    s_d.rdata[wrba_pkg::COMM_SEL_LSB +: wrba_pkg::ADDR_W] = s_q.readback_select;
                end
                default: s_d.rdata = wrba_pkg::WORD_ZERO;
            endcase
            // read of the last location closes the dump
            if (s_q.state == wrba_pkg::ST_DUMP && s_q.last) begin
                s_d.state = wrba_pkg::ST_IDLE;
                s_d.last = 1'b0;
            end
        end

        // command interpreter on reference-register writes
        case (s_q.state)
            wrba_pkg::ST_IDLE: begin
                if (wr_ref) begin
                    // store refused outside ram play mode, dump outside 2/3
                    if (s_q.data_s2 == wrba_pkg::CMD_BURST_STORE
                        && s_q.mode == wrba_pkg::MODE_RAM_PLAY) begin
                        s_d.state = wrba_pkg::ST_START;
                    end else if (s_q.data_s2 == wrba_pkg::CMD_DUMP
                        && (s_q.mode == wrba_pkg::MODE_RAM_PLAY
                        || s_q.mode == wrba_pkg::MODE_RAM_SYNTH)) begin
                        s_d.state = wrba_pkg::ST_DUMP;
                        s_d.raddr = wrba_pkg::COUNT_ZERO;
                        s_d.last = 1'b0;
                    end else begin
                        s_d.sample = s_q.data_s2; // plain direct sample
                    end
                end
            end
            wrba_pkg::ST_START: begin
                if (wr_ref) begin
                    s_d.waddr = s_q.data_s2[wrba_pkg::RAM_AW-1:0];
                    s_d.state = wrba_pkg::ST_COUNT;
                end
            end
            wrba_pkg::ST_COUNT: begin
                if (wr_ref) begin
                    s_d.wcnt = s_q.data_s2[wrba_pkg::RAM_AW-1:0];
                    // a zero count carries no data words
                    if (s_q.data_s2[wrba_pkg::RAM_AW-1:0] == wrba_pkg::COUNT_ZERO) begin
                        s_d.state = wrba_pkg::ST_IDLE;
                    end else begin
                        s_d.state = wrba_pkg::ST_DATA;
                    end
                end
            end
            wrba_pkg::ST_DATA: begin
                if (wr_ref) begin
                    ram_we = 1'b1;
                    s_d.waddr = s_q.waddr + wrba_pkg::COUNT_ONE;
                    s_d.wcnt = s_q.wcnt - wrba_pkg::COUNT_ONE;
                    if (s_q.wcnt == wrba_pkg::COUNT_ONE) begin
                        s_d.state = wrba_pkg::ST_IDLE;
                    end
                end
            end
            wrba_pkg::ST_DUMP: begin
                if (wr_ref) begin
                    if (s_q.data_s2 == wrba_pkg::CMD_DUMP_ABORT) begin
                        s_d.state = wrba_pkg::ST_IDLE;
                        s_d.last = 1'b0;
                    end else begin
                        // filler fetches the next location
                        s_d.ram_data = ram[s_q.raddr];
                        s_d.raddr = s_q.raddr + wrba_pkg::COUNT_ONE;
                        s_d.last = (s_q.raddr == wrba_pkg::RAM_LAST);
                    end
                end
            end
            default: s_d.state = wrba_pkg::ST_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // state register; ce low freezes everything
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.state <= wrba_pkg::ST_IDLE;
            s_q.mode <= wrba_pkg::MODE_RESET;
            s_q.readback_select <= wrba_pkg::SEL_RESET;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ram write port; ram itself has no reset, contents are undefined
    always_ff @(posedge core_clk) begin
        if (ce && !rst && ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.rdata = s_q.rdata;
    assign pb_data = s_q.pb_data;
    assign ref_sample = s_q.sample[wrba_pkg::SAMPLE_W-1:0];
    assign play_mode = s_q.mode;
    assign dump_active = (s_q.state == wrba_pkg::ST_DUMP);
endmodule : wrba_device
`default_nettype wire

// [core/wrba_host.sv]
/*
 * host end: turns single register write/read requests into link
 * transfers, making link_clk from the core clock by a divider.
 * assumes the user side sequences commands (store, dump, filler,
 * reads) and keeps the play-mode and readback-select preconditions.
 */
`timescale 1ns/1ps
`default_nettype none
module wrba_host #(
    parameter int HALF_CYC = wrba_pkg::LINK_HALF_CYC
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // control link
    wrba_link_if.host_mp link,
    // request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [4:0] req_addr,
    input wire logic [15:0] req_data,
    // answer side
    output logic rsp_valid,
    output logic [15:0] rsp_data
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] div;
        logic lclk;
        wrba_pkg::wrba_hstate_t st;
        logic wr;
        logic rd;
        logic is_read;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic rsp;
        logic [15:0] rdata;
        logic [15:0] rdata_s1;
        logic [15:0] rdata_s2;
    } wrba_host_t;

    wrba_host_t h_q;
    wrba_host_t h_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // strobes change on falling link edges so the device samples
    // mid-period; a transfer spans two link periods for read settling
    always_comb begin
        logic fall;
        fall = 1'b0;
        h_d = h_q;
        h_d.rsp = 1'b0;
        // readback word comes from the far end: two flops before use
        h_d.rdata_s1 = link.rdata;
        h_d.rdata_s2 = h_q.rdata_s1;
        if (h_q.div == 8'(HALF_CYC - 1)) begin
            h_d.div = 8'h00;
            h_d.lclk = !h_q.lclk;
            fall = h_q.lclk;
        end else begin
            h_d.div = h_q.div + 8'h01;
        end
        case (h_q.st)
            wrba_pkg::HS_IDLE: begin
                if (req_valid) begin
                    h_d.st = wrba_pkg::HS_WAIT;
                    h_d.is_read = req_read;
                    h_d.addr = req_addr;
                    h_d.wdata = req_data;
                end
            end
            wrba_pkg::HS_WAIT: begin
                if (fall) begin
                    h_d.st = wrba_pkg::HS_DRIVE;
                    h_d.wr = !h_q.is_read;
                    h_d.rd = h_q.is_read;
                end
            end
            wrba_pkg::HS_DRIVE: begin
                if (fall) begin
                    h_d.st = wrba_pkg::HS_HOLD;
                    h_d.wr = 1'b0;
                    h_d.rd = 1'b0;
                end
            end
            wrba_pkg::HS_HOLD: begin
                if (fall) begin
                    h_d.st = wrba_pkg::HS_IDLE;
                    h_d.rsp = 1'b1;
                    h_d.rdata = h_q.is_read ? h_q.rdata_s2 : wrba_pkg::WORD_ZERO;
                end
            end
            default: h_d.st = wrba_pkg::HS_IDLE;
        endcase
    end

    // state register; ce low freezes the divider as well
    always_ff @(posedge core_clk) begin
        if (rst) begin
            h_q <= '0;
            h_q.st <= wrba_pkg::HS_IDLE;
        end else if (ce) begin
            h_q <= h_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign req_ready = (h_q.st == wrba_pkg::HS_IDLE);
    assign rsp_valid = h_q.rsp;
    assign rsp_data = h_q.rdata;
    assign link.link_clk = h_q.lclk;
    assign link.wr_en = h_q.wr;
    assign link.rd_en = h_q.rd;
    assign link.addr = h_q.addr;
    assign link.wdata = h_q.wdata;
endmodule : wrba_host
`default_nettype wire

// [sim/wrba_link_monitor.sv]
/*
 * link monitor: assertions on the host-device link signals.
 * assumes HALF_CYC equals the host instance's divider setting.
 */
`timescale 1ns/1ps
`default_nettype none
module wrba_link_monitor #(
    parameter int HALF_CYC = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // link signals
    input wire logic link_clk,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic [7:0] wr_n_q;
    logic [7:0] rd_n_q;
    logic [7:0] hi_n_q;
    logic [7:0] since_rd_q;
    logic [4:0] sel_q;

    // strobe and link-high lengths; since_rd saturates to stay quiet
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_n_q <= 8'h00;
            rd_n_q <= 8'h00;
            hi_n_q <= 8'h00;
            since_rd_q <= 8'h00;
            sel_q <= wrba_pkg::SEL_RESET;
        end else if (ce) begin
            wr_n_q <= wr_en ? wr_n_q + 8'h01 : 8'h00;
            rd_n_q <= rd_en ? rd_n_q + 8'h01 : 8'h00;
            hi_n_q <= link_clk ? hi_n_q + 8'h01 : 8'h00;
            since_rd_q <= rd_en ? 8'h00 : (&since_rd_q ? since_rd_q : since_rd_q + 8'h01);
            if ($rose(wr_en) && addr == wrba_pkg::REG_COMM) begin
                sel_q <= wdata[4:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    chk_strobe_excl: assert property (!(wr_en && rd_en))
        else $error("write and read strobes both high");
    chk_wr_len: assert property ($fell(wr_en) |-> wr_n_q == 8'(2 * HALF_CYC))
        else $error("write strobe not one link period");
    chk_rd_len: assert property ($fell(rd_en) |-> rd_n_q == 8'(2 * HALF_CYC))
        else $error("read strobe not one link period");
    chk_link_half: assert property ($fell(link_clk) |-> hi_n_q == 8'(HALF_CYC))
        else $error("link clock high phase wrong");
    chk_strobe_launch: assert property ($rose(wr_en) || $rose(rd_en) |-> !link_clk)
        else $error("strobe raised while link clock high");
    chk_word_hold: assert property (wr_en && $past(wr_en) |-> $stable(addr) && $stable(wdata))
        else $error("write word changed under strobe");
    chk_rdata_hold: assert property ($changed(rdata) |-> since_rd_q < 8'h0c)
        else $error("readback changed without a read");
    chk_reset_quiet: assert property ($fell(rst) |-> !wr_en && !rd_en && rdata == 16'h0000)
        else $error("link not quiet after reset");
    chk_dump_select: assert property ($rose(wr_en) && addr == wrba_pkg::REG_REFERENCE
        && wdata == wrba_pkg::CMD_DUMP |-> sel_q == wrba_pkg::REG_RAM_DATA)
        else $error("dump issued without ram data select");

    // main scenarios seen on the wire
    cov_store: cover property ($rose(wr_en) && wdata == wrba_pkg::CMD_BURST_STORE);
    cov_dump: cover property ($rose(wr_en) && wdata == wrba_pkg::CMD_DUMP);
    cov_abort: cover property ($rose(wr_en) && wdata == wrba_pkg::CMD_DUMP_ABORT);
endmodule : wrba_link_monitor
`default_nettype wire

// [sim/waveform_ram_block_access_tb.sv]
/*
 * testbench: host and device joined by the link interface.
 * assumes the bench keeps mode and select preconditions itself.
 */
`timescale 1ns/1ps
`default_nettype none
module waveform_ram_block_access_tb;
    localparam int HALF = 2;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    logic req_read = 1'b0;
    logic [4:0] req_addr = 5'h00;
    logic [15:0] req_data = 16'h0000;
    logic [9:0] pb_addr = 10'h000;
    logic req_ready, rsp_valid, dump_active;
    logic [15:0] rsp_data, pb_data, d;
    logic [11:0] ref_sample;
    logic [1:0] play_mode;
    logic [15:0] exp_q[$];
    logic [15:0] ram_m [1024];
    int n_fail = 0;
    int total_checks = 0;
    int n_rsp = 0;
    int seed = 32'he0af;

    wrba_link_if link_i ();
    wrba_host #(.HALF_CYC(HALF)) wrba_host_i (.core_clk(core_clk), .rst(rst), .ce(ce),
        .link(link_i.host_mp), .req_valid(req_valid), .req_ready(req_ready),
        .req_read(req_read), .req_addr(req_addr), .req_data(req_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    wrba_device wrba_device_i (.core_clk(core_clk), .rst(rst), .ce(ce),
        .link(link_i.dev_mp), .pb_addr(pb_addr), .pb_data(pb_data),
        .ref_sample(ref_sample), .play_mode(play_mode), .dump_active(dump_active));
    wrba_link_monitor #(.HALF_CYC(HALF)) wrba_link_monitor_i (.core_clk(core_clk), .ce(ce),
        .rst(rst), .link_clk(link_i.link_clk), .wr_en(link_i.wr_en), .rd_en(link_i.rd_en),
        .addr(link_i.addr), .wdata(link_i.wdata), .rdata(link_i.rdata));

    // 50 ns core clock
    initial begin
        forever #25 core_clk = ~core_clk;
    end

    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    // answers are compared at negedge, clear of the launching edge
    always @(negedge core_clk) begin
        if (rsp_valid === 1'b1) begin
            n_rsp++;
            check(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : ~rsp_data);
        end
    end

    // one transfer; entered and left just after a rising edge
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [15:0] v,
                        input logic [15:0] want);
        int n0;
        n0 = n_rsp;
        exp_q.push_back(want);
        req_read = rd;
        req_addr = a;
        req_data = v;
        req_valid = 1'b1;
        @(posedge core_clk);
        #1 req_valid = 1'b0;
        check({15'h0000, req_ready}, 16'h0000);
        for (int i = 0; i < 200 && n_rsp == n0; i++) @(posedge core_clk);
        if (n_rsp == n0) begin
            n_fail++;
            close_out();
        end
        #1;
        check({15'h0000, req_ready}, 16'h0001);
    endtask : xfer

    task automatic rd(input logic [15:0] want);
        xfer(1'b1, wrba_pkg::REG_RAM_DATA, 16'h0000, want);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        xfer(1'b0, a, v, 16'h0000);
    endtask : wr

    task automatic wref(input logic [15:0] v);
        xfer(1'b0, wrba_pkg::REG_REFERENCE, v, 16'h0000);
    endtask : wref

    task automatic burst(input logic [9:0] start, input int cnt);
        wref(wrba_pkg::CMD_BURST_STORE);
        wref({6'h00, start});
        wref(16'(cnt));
        for (int i = 0; i < cnt; i++) begin
            d = 16'($random(seed));
            ram_m[10'(start + i)] = d;
            wref(d);
        end
    endtask : burst

    task automatic pb_chk(input logic [9:0] a);
        pb_addr = a;
        repeat (2) @(posedge core_clk);
        #1 check(pb_data, ram_m[a]);
    endtask : pb_chk

    task automatic dump_step(input logic [9:0] a);
        d = 16'($random(seed));
        if (d == wrba_pkg::CMD_DUMP_ABORT) d = wrba_pkg::FILLER_WORD;
        wref(d);
        xfer(1'b1, wrba_pkg::REG_RAM_DATA, 16'h0000, ram_m[a]);
    endtask : dump_step

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        #1 rst = 1'b0;
        // commands outside ram modes fall through as plain samples
        wref(wrba_pkg::CMD_BURST_STORE);
        check({4'h0, ref_sample}, 16'h0014);
        // unmapped select reads zero, reference select reads the sample
        rd(16'h0000);
        wr(wrba_pkg::REG_COMM, {11'h000, wrba_pkg::REG_REFERENCE});
        rd(16'h0014);
        wr(wrba_pkg::REG_COMM, 16'h001b);
        wref(wrba_pkg::CMD_DUMP);
        check({15'h0000, dump_active}, 16'h0000);
        $display("test refusal done");
        wr(wrba_pkg::REG_CONFIG, {5'h00, wrba_pkg::MODE_RAM_PLAY, 9'h000});
        check({14'h0000, play_mode}, 16'h0002);
        // config and comm readback, then ram data select again
        wr(wrba_pkg::REG_COMM, {11'h000, wrba_pkg::REG_CONFIG});
        rd({5'h00, wrba_pkg::MODE_RAM_PLAY, 9'h000});
        wr(wrba_pkg::REG_COMM, {11'h000, wrba_pkg::REG_COMM});
        rd({11'h000, wrba_pkg::REG_COMM});
        wr(wrba_pkg::REG_COMM, {11'h000, wrba_pkg::REG_RAM_DATA});
        // first burst wraps past the top address
        burst(10'h3fe, 4);
        burst(10'h002, 1020);
        wref(16'h0abc);
        check({4'h0, ref_sample}, 16'h0abc);
        foreach (ram_m[i]) if (i % 97 == 0 || i < 4 || i > 1019) pb_chk(10'(i));
        // ce low freezes the playback read register
        ce = 1'b0;
        pb_addr = 10'h001;
        repeat (3) @(posedge core_clk);
        #1 check(pb_data, ram_m[10'h3ff]);
        ce = 1'b1;
        pb_chk(10'h001);
        $display("test burst store done");
        // full dump runs to the last address and then leaves dump mode
        wref(wrba_pkg::CMD_DUMP);
        check({15'h0000, dump_active}, 16'h0001);
        for (int k = 0; k < 1024; k++) begin
            dump_step(10'(k));
            if (k == 1022) check({15'h0000, dump_active}, 16'h0001);
        end
        check({15'h0000, dump_active}, 16'h0000);
        $display("test full dump done");
        // dump in synthesis mode, broken off after three steps
        wr(wrba_pkg::REG_CONFIG, {5'h00, wrba_pkg::MODE_RAM_SYNTH, 9'h000});
        wref(wrba_pkg::CMD_DUMP);
        for (int k = 0; k < 3; k++) dump_step(10'(k));
        check({15'h0000, dump_active}, 16'h0001);
        wref(wrba_pkg::CMD_DUMP_ABORT);
        check({15'h0000, dump_active}, 16'h0000);
        wref(16'h0123);
        check({4'h0, ref_sample}, 16'h0123);
        $display("test dump abort done");
        // reset in mid-dump: interpreter idles, ram keeps its words
        wref(wrba_pkg::CMD_DUMP);
        check({15'h0000, dump_active}, 16'h0001);
        rst = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        check({15'h0000, dump_active}, 16'h0000);
        check({14'h0000, play_mode}, 16'h0000);
        rd(16'h0000);
        pb_chk(10'h005);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : waveform_ram_block_access_tb
`default_nettype wire
